// ===== logic/sps_ctrl.sv
// Operation
// (RULE1) Capture tx word on each tx word clock rising edge into input register.
// (RULE2) Transmit word bit 15 is sent first on the serial line.
// (RULE3) Transmit word clock output is transmit bit clock divided by sixteen.
// (RULE4) Upstream uses the word clock output and presents data with its input clock.
// (RULE5) Receive word changes only after the receive word clock falling edge.
// (RULE6) Receive word bit 15 holds the earliest received bit.
// (RULE7) Receive word clock is the recovered bit clock divided by sixteen.
// (RULE8) Reference times both PLLs and the transmit parallel interface.
// (RULE9) Line fault low when signal detect low or receive VCO out of range.
// (RULE10) Reset clears all logic except the transmit FIFO.
// (RULE11) Lock-to-reference low makes receive PLL follow the reference.
// (RULE12) Signal detect low also makes receive PLL follow the reference.
// (RULE13) FIFO under or overflow raises error and clears within nine cycles.
// (RULE14) FIFO reset input low sets pointers at maximum separation.
// (RULE15) FIFO reset is applied automatically at power-up.
// (RULE16) Serial output is 1010 pattern while the FIFO is held.
// (RULE17) Standby low disables all logic and the line driver.
// (RULE18) Loop timing selects recovered clock, else reference times sixteen.
// (RULE19) FIFO absorbs phase between word input clock and character clock.
// (RULE20) Overflow on write into full FIFO, underflow on read of empty one.
`timescale 1ns/1ns
`default_nettype none
module sps_ctrl (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // Reference and mode control
  input wire logic reference_clock_in,
  input wire logic loop_timing_sel_in,
  input wire logic lock_to_reference_n_in,
  input wire logic signal_detect_in,
  input wire logic rx_vco_in_range_in,
  input wire logic standby_n_in,
  input wire logic tx_buffer_reset_n_in,
  // Transmit parallel side
  input wire logic tx_word_clk_in,
  input wire logic [sps_pkg::WORD_W-1:0] tx_word_in,
  output logic tx_word_clk_out,
  output logic tx_buffer_error_out,
  // Transmit serial side
  output logic tx_serial_out,
  output logic tx_serial_en_out,
  // Receive serial side
  input wire logic rx_serial_in,
  input wire logic rx_bit_tick_in,
  // Receive parallel side and status
  output logic rx_word_clk_out,
  output logic [sps_pkg::WORD_W-1:0] rx_word_out,
  output logic rx_overrun_out,
  output logic line_fault_n_out
);
  import sps_pkg::*;

  logic run;
  logic ref_tick;
  logic rx_lock_ref;
  logic rx_tick;
  logic tx_tick;

  // Reference multiplier
  logic ref_prev_reg;
  logic ref_prev_next;
  logic [4:0] ref_burst_reg;
  logic [4:0] ref_burst_next;

  // Transmit input register
  logic twc_prev_reg;
  logic twc_prev_next;
  logic [WORD_W-1:0] tx_in_reg;
  logic [WORD_W-1:0] tx_in_next;
  logic tx_in_vld_reg;
  logic tx_in_vld_next;

  // Transmit FIFO
  logic [WORD_W-1:0] fifo_mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wr_ptr_reg;
  logic [FIFO_AW-1:0] wr_ptr_next;
  logic [FIFO_AW-1:0] rd_ptr_reg;
  logic [FIFO_AW-1:0] rd_ptr_next;
  logic [3:0] fill_reg;
  logic [3:0] fill_next;
  sps_fifo_st_t fst_reg;
  sps_fifo_st_t fst_next;
  logic [3:0] clr_cnt_reg;
  logic [3:0] clr_cnt_next;
  logic err_reg;
  logic err_next;
  // Power-up value only; never touched by resetn_in
  logic por_done_reg = 1'b0;
  logic pin_hold;
  logic fifo_hold;
  logic fifo_wr;
  logic fifo_rd;
  logic fifo_ovf;
  logic fifo_unf;
  logic mem_we;

  // Serializer
  logic [3:0] tx_cnt_reg;
  logic [3:0] tx_cnt_next;
  logic [WORD_W-1:0] tx_sh_reg;
  logic [WORD_W-1:0] tx_sh_next;
  logic tx_wclk_reg;
  logic tx_wclk_next;
  logic tx_en_reg;
  logic tx_en_next;

  // Deserializer
  logic [3:0] rx_cnt_reg;
  logic [3:0] rx_cnt_next;
  logic [WORD_W-1:0] rx_sh_reg;
  logic [WORD_W-1:0] rx_sh_next;
  logic rx_wclk_reg;
  logic rx_wclk_next;
  logic [WORD_W-1:0] rx_out_reg;
  logic [WORD_W-1:0] rx_out_next;
  logic ovr_reg;
  logic ovr_next;
  logic lfi_reg;
  logic lfi_next;

  sps_stream_if rx_in_if ();
  sps_stream_if rx_out_if ();

  // Standby behaves as a held reset for everything but the FIFO, which pin_hold holds instead
  assign run = resetn_in && standby_n_in; // [RULE10] [RULE17]

  // Clock selection
  always_comb begin
    ref_tick = ref_burst_reg != 5'h00;
    rx_lock_ref = !lock_to_reference_n_in || !signal_detect_in; // [RULE11] [RULE12]
    rx_tick = rx_lock_ref ? ref_tick : rx_bit_tick_in; // [RULE8]
    tx_tick = loop_timing_sel_in ? rx_tick : ref_tick; // [RULE18]
  end

  // Sixteen bit ticks per reference edge stand in for the PLL multiplier
  always_comb begin
    ref_prev_next = reference_clock_in;
    ref_burst_next = ref_burst_reg;
    if (ref_burst_reg != 5'h00) begin
      ref_burst_next = ref_burst_reg - 5'h01;
    end
    if (reference_clock_in && !ref_prev_reg) begin
      ref_burst_next = REF_MULT; // [RULE18] [RULE8]
    end
    if (!run) begin
      ref_prev_next = 1'b0;
      ref_burst_next = 5'h00;
    end
  end

  always_ff @(posedge core_clk_in) begin
    ref_prev_reg <= ref_prev_next;
    ref_burst_reg <= ref_burst_next;
  end

  // Input register
  always_comb begin
    twc_prev_next = tx_word_clk_in;
    tx_in_next = tx_in_reg;
    tx_in_vld_next = tx_word_clk_in && !twc_prev_reg;
    if (tx_word_clk_in && !twc_prev_reg) begin
      tx_in_next = tx_word_in; // [RULE1]
    end
    if (!run) begin
      twc_prev_next = 1'b0;
      tx_in_next = '0;
      tx_in_vld_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    twc_prev_reg <= twc_prev_next;
    tx_in_reg <= tx_in_next;
    tx_in_vld_reg <= tx_in_vld_next;
  end

  // Transmit FIFO: written from the input clock side, read per character
  always_comb begin
    pin_hold = !tx_buffer_reset_n_in || !por_done_reg || !standby_n_in; // [RULE14] [RULE15]
    fifo_hold = pin_hold || fst_reg == FS_CLEAR;
    fifo_wr = tx_in_vld_reg;
    fifo_rd = run && tx_tick && sps_last_bit(tx_cnt_reg); // [RULE19]
    fifo_unf = fifo_rd && fill_reg == 4'h0; // [RULE20]
    fifo_ovf = fifo_wr && !fifo_rd && fill_reg == FIFO_FULL; // [RULE20]
    mem_we = 1'b0;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    fill_next = fill_reg;
    fst_next = fst_reg;
    clr_cnt_next = clr_cnt_reg;
    err_next = err_reg;
    if (pin_hold) begin
      wr_ptr_next = FIFO_WR_START; // [RULE14]
      rd_ptr_next = FIFO_RD_START;
      fill_next = FIFO_HALF;
      fst_next = FS_RUN;
      clr_cnt_next = 4'h0;
      err_next = 1'b0;
    end else begin
      case (fst_reg)
        FS_RUN: begin
          if (fifo_ovf || fifo_unf) begin
            fst_next = FS_CLEAR; // [RULE13]
            clr_cnt_next = CLR_CYC;
            err_next = 1'b1;
          end else begin
            mem_we = fifo_wr;
            if (fifo_wr) begin
              wr_ptr_next = wr_ptr_reg + 3'h1;
            end
            if (fifo_rd) begin
              rd_ptr_next = rd_ptr_reg + 3'h1;
            end
            if (fifo_wr && !fifo_rd) begin
              fill_next = fill_reg + 4'h1;
            end else if (fifo_rd && !fifo_wr) begin
              fill_next = fill_reg - 4'h1;
            end
          end
        end
        FS_CLEAR: begin
          wr_ptr_next = FIFO_WR_START; // [RULE13]
          rd_ptr_next = FIFO_RD_START;
          fill_next = FIFO_HALF;
          clr_cnt_next = clr_cnt_reg - 4'h1;
          if (clr_cnt_reg == 4'h1) begin
            fst_next = FS_RUN;
            err_next = 1'b0;
          end
        end
        default: begin
          fst_next = FS_RUN;
        end
      endcase
    end
  end

  // Not reset by resetn_in: only the FIFO reset pin, standby, power-up and the error clear recentre it
  always_ff @(posedge core_clk_in) begin
    por_done_reg <= 1'b1; // [RULE15]
    wr_ptr_reg <= wr_ptr_next; // [RULE10]
    rd_ptr_reg <= rd_ptr_next;
    fill_reg <= fill_next;
    fst_reg <= fst_next;
    clr_cnt_reg <= clr_cnt_next;
    err_reg <= err_next;
  end

  always_ff @(posedge core_clk_in) begin
    if (mem_we) begin
      fifo_mem[wr_ptr_reg] <= tx_in_reg;
    end
  end

  // Serializer: MSB leaves first, new word at the character boundary
  always_comb begin
    tx_cnt_next = tx_cnt_reg;
    tx_sh_next = tx_sh_reg;
    tx_en_next = 1'b1;
    if (tx_tick) begin
      tx_cnt_next = tx_cnt_reg + 4'h1; // [RULE3]
      if (sps_last_bit(tx_cnt_reg)) begin
        if (fifo_hold || fifo_unf) begin
          tx_sh_next = IDLE_PATTERN; // [RULE16]
        end else begin
          tx_sh_next = fifo_mem[rd_ptr_reg];
        end
      end else begin
        tx_sh_next = {tx_sh_reg[WORD_W-2:0], 1'b0}; // [RULE2]
      end
    end
    tx_wclk_next = tx_cnt_next < HALF_WORD; // [RULE3]
    if (!run) begin
      tx_cnt_next = 4'h0;
      tx_sh_next = IDLE_PATTERN;
      tx_wclk_next = 1'b0;
      tx_en_next = 1'b0; // [RULE17]
    end
  end

  always_ff @(posedge core_clk_in) begin
    tx_cnt_reg <= tx_cnt_next;
    tx_sh_reg <= tx_sh_next;
    tx_wclk_reg <= tx_wclk_next;
    tx_en_reg <= tx_en_next;
  end

  // Deserializer: first bit ends up in bit 15
  always_comb begin
    rx_cnt_next = rx_cnt_reg;
    rx_sh_next = rx_sh_reg;
    rx_out_next = rx_out_reg;
    rx_in_if.valid = 1'b0;
    rx_in_if.data = {rx_sh_reg[WORD_W-2:0], rx_serial_in}; // [RULE6]
    rx_out_if.ready = rx_tick && rx_cnt_reg == HALF_WORD - 4'h1; // [RULE5]
    if (rx_tick) begin
      rx_cnt_next = rx_cnt_reg + 4'h1; // [RULE7]
      rx_sh_next = {rx_sh_reg[WORD_W-2:0], rx_serial_in};
      rx_in_if.valid = run && sps_last_bit(rx_cnt_reg);
    end
    if (rx_out_if.valid && rx_out_if.ready) begin
      rx_out_next = rx_out_if.data; // [RULE5]
    end
    rx_wclk_next = rx_cnt_next < HALF_WORD; // [RULE7]
    // Serial line cannot stall, so a refused word is counted as overrun
    ovr_next = ovr_reg || (rx_in_if.valid && !rx_in_if.ready);
    lfi_next = signal_detect_in && rx_vco_in_range_in; // [RULE9]
    if (!run) begin
      rx_cnt_next = 4'h0;
      rx_sh_next = '0;
      rx_out_next = '0;
      rx_wclk_next = 1'b0;
      ovr_next = 1'b0;
      lfi_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    rx_cnt_reg <= rx_cnt_next;
    rx_sh_reg <= rx_sh_next;
    rx_wclk_reg <= rx_wclk_next;
    rx_out_reg <= rx_out_next;
    ovr_reg <= ovr_next;
    lfi_reg <= lfi_next;
  end

  sps_word_buf u_rx_buf (
    .clk_in(core_clk_in),
    .resetn_in(run),
    .up(rx_in_if.snk),
    .dn(rx_out_if.src)
  );

  assign tx_word_clk_out = tx_wclk_reg;
  assign tx_buffer_error_out = err_reg;
  assign tx_serial_out = tx_sh_reg[WORD_W-1];
  assign tx_serial_en_out = tx_en_reg;
  assign rx_word_clk_out = rx_wclk_reg;
  assign rx_word_out = rx_out_reg;
  assign rx_overrun_out = ovr_reg;
  assign line_fault_n_out = lfi_reg;
endmodule // sps_ctrl
`default_nettype wire

// ===== logic/sps_word_buf.sv
`timescale 1ns/1ns
`default_nettype none
module sps_word_buf (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Streams
  sps_stream_if.snk up,
  sps_stream_if.src dn
);
  import sps_pkg::*;

  logic [WORD_W-1:0] ent_reg [BUF_DEPTH];
  logic wp_reg;
  logic wp_next;
  logic rp_reg;
  logic rp_next;
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic push;
  logic pop;

  assign up.ready = cnt_reg != BUF_FULL;
  assign dn.valid = cnt_reg != 2'h0;
  assign dn.data = ent_reg[rp_reg];

  always_comb begin
    push = up.valid && up.ready;
    pop = dn.valid && dn.ready;
    wp_next = push ? ~wp_reg : wp_reg;
    rp_next = pop ? ~rp_reg : rp_reg;
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + 2'h1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 2'h1;
    end
    if (!resetn_in) begin
      wp_next = 1'b0;
      rp_next = 1'b0;
      cnt_next = 2'h0;
    end
  end

  always_ff @(posedge clk_in) begin
    wp_reg <= wp_next;
    rp_reg <= rp_next;
    cnt_reg <= cnt_next;
  end

  // Storage needs no reset; the count guards it
  always_ff @(posedge clk_in) begin
    if (push) begin
      ent_reg[wp_reg] <= up.data;
    end
  end
endmodule // sps_word_buf
`default_nettype wire

// ===== pkg/sps_pkg.sv
`default_nettype none
package sps_pkg;
  // Word and bit framing
  localparam int WORD_W = 16;
  localparam int CNT_W = 4;
  localparam logic [3:0] LAST_BIT = 4'hF;
  localparam logic [3:0] HALF_WORD = 4'h8;
  // Reference multiplier: bit ticks per reference rising edge
  localparam logic [4:0] REF_MULT = 5'h10;
  // Transmit FIFO layout
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_AW = 3;
  localparam logic [3:0] FIFO_FULL = 4'h8;
  localparam logic [3:0] FIFO_HALF = 4'h4;
  localparam logic [2:0] FIFO_WR_START = 3'h4;
  localparam logic [2:0] FIFO_RD_START = 3'h0;
  // Automatic clear after an error, bounded by the limit
  localparam int CLR_LIMIT_CYC = 9;
  localparam logic [3:0] CLR_CYC = 4'(CLR_LIMIT_CYC - 1);
  // Serial idle pattern while the FIFO is held
  localparam logic [15:0] IDLE_PATTERN = 16'hAAAA;
  // Receive output buffer
  localparam int BUF_DEPTH = 2;
  localparam logic [1:0] BUF_FULL = 2'h2;

  typedef enum logic {FS_RUN, FS_CLEAR} sps_fifo_st_t;

  function automatic logic sps_last_bit(input logic [3:0] cnt);
    return cnt == LAST_BIT;
  endfunction
endpackage
`default_nettype wire

// ===== pkg/sps_stream_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sps_stream_if;
  logic valid;
  logic ready;
  logic [sps_pkg::WORD_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== verif/sps_ctrl_chk.sv
`timescale 1ns/1ns
`default_nettype none
module sps_ctrl_chk (
  // Clock, reset and controls
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic loop_timing_sel_in,
  input wire logic lock_to_reference_n_in,
  input wire logic signal_detect_in,
  input wire logic rx_vco_in_range_in,
  input wire logic standby_n_in,
  input wire logic rx_bit_tick_in,
  // Outputs watched
  input wire logic tx_word_clk_out,
  input wire logic tx_buffer_error_out,
  input wire logic tx_serial_out,
  input wire logic tx_serial_en_out,
  input wire logic rx_word_clk_out,
  input wire logic [sps_pkg::WORD_W-1:0] rx_word_out,
  input wire logic line_fault_n_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  // Outputs jump on entering reset or standby, so relations start one cycle later
  wire logic live = resetn_in && standby_n_in;
  wire logic own_tick = lock_to_reference_n_in && signal_detect_in;
  sequence err_burst;
    tx_buffer_error_out [*8] ##1 !tx_buffer_error_out;
  endsequence
  a_fault_follows: assert property ($past(live) |->
    line_fault_n_out == ($past(signal_detect_in) && $past(rx_vco_in_range_in))) else $error("line fault wrong");
  a_standby_quiet: assert property (!standby_n_in |=> !line_fault_n_out && !tx_serial_en_out)
    else $error("standby left outputs active");
  a_driver_on: assert property ($past(live) |-> tx_serial_en_out)
    else $error("line driver off while running");
  a_err_clears: assert property ($rose(tx_buffer_error_out) |-> err_burst)
    else $error("fifo error span wrong");
  a_rx_word_hold: assert property ($past(live) && !$stable(rx_word_out) |-> $fell(rx_word_clk_out))
    else $error("receive word moved off clock fall");
  // Word clocks leave their reset low on the first running edge, tick or not
  a_rx_tick_only: assert property ($past(live) && $past(live, 2) && $past(own_tick) && !$past(rx_bit_tick_in) |->
    $stable(rx_word_clk_out)) else $error("receive clock moved without tick");
  a_tx_loop_tick: assert property ($past(live) && $past(live, 2) && $past(loop_timing_sel_in) && $past(own_tick)
    && !$past(rx_bit_tick_in) |-> $stable(tx_serial_out) && $stable(tx_word_clk_out))
    else $error("transmit moved without recovered tick");
  a_reset_values: assert property (!$past(resetn_in) |-> tx_serial_out && !tx_word_clk_out
    && !rx_word_clk_out && rx_word_out == '0 && !line_fault_n_out) else $error("reset values wrong");
endmodule // sps_ctrl_chk
bind sps_ctrl sps_ctrl_chk chk (.core_clk_in, .resetn_in, .loop_timing_sel_in, .lock_to_reference_n_in,
  .signal_detect_in, .rx_vco_in_range_in, .standby_n_in, .rx_bit_tick_in, .tx_word_clk_out,
  .tx_buffer_error_out, .tx_serial_out, .tx_serial_en_out, .rx_word_clk_out, .rx_word_out, .line_fault_n_out);
`default_nettype wire

// ===== verif/sps_ctrl_test.sv
`timescale 1ns/1ns
`default_nettype none
module sps_ctrl_test;
  import sps_pkg::*;
  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic standby_n_in = 1'b1;
  logic tx_buffer_reset_n_in = 1'b1;
  logic signal_detect_in = 1'b1;
  logic rx_vco_in_range_in = 1'b1;
  logic rx_serial_in = 1'b0;
  logic rx_bit_tick_in = 1'b0;
  logic up_en = 1'b1;
  logic up_burst = 1'b0;
  wire logic wclk, tx_word_clk_out, tx_buffer_error_out, tx_serial_out, tx_serial_en_out;
  wire logic rx_word_clk_out, line_fault_n_out, rx_overrun_out;
  wire logic [WORD_W-1:0] wdata, rx_word_out;
  int miscompares = 0;
  int n_tests = 0;
  // First word clock fall comes before any complete word
  int k = 0, rj = -1, md = 0, skip = 0, nfr = 0, err_run = 0, err_max = 0;
  logic [15:0] txs = 16'h0000, lastw = 16'h0000;
  logic txc_q = 1'b0, rxc_q = 1'b0;
  always #5 core_clk_in = ~core_clk_in;
  // Reference tied idle: loop timing runs everything from the pin ticks
  sps_ctrl dut (.core_clk_in, .resetn_in, .reference_clock_in(1'b0), .loop_timing_sel_in(1'b1),
    .lock_to_reference_n_in(1'b1), .signal_detect_in, .rx_vco_in_range_in, .standby_n_in,
    .tx_buffer_reset_n_in, .tx_word_clk_in(wclk), .tx_word_in(wdata), .tx_word_clk_out, .tx_buffer_error_out,
    .tx_serial_out, .tx_serial_en_out, .rx_serial_in, .rx_bit_tick_in, .rx_word_clk_out, .rx_word_out,
    .rx_overrun_out, .line_fault_n_out);
  sps_framer_model upm (.clk_in(core_clk_in), .resetn_in, .enable_in(up_en), .burst_in(up_burst),
    .word_clk_in(tx_word_clk_out), .word_clk_out(wclk), .word_out(wdata));
  always @(negedge core_clk_in) begin
    err_run = (tx_buffer_error_out === 1'b1) ? err_run + 1 : 0;
    if (err_run > err_max) err_max = err_run;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
    @(negedge core_clk_in);
  endtask
  // One recovered bit per loop pass, n per call, four cycles apart; both directions sampled
  task automatic tick(input int n);
    logic [15:0] w;
    repeat (n) begin
      w = {8'h5A, 8'(k / 16)};
      @(posedge core_clk_in);
      rx_bit_tick_in <= 1'b1;
      rx_serial_in <= w[15 - k % 16];
      @(posedge core_clk_in);
      rx_bit_tick_in <= 1'b0;
      rx_serial_in <= ~w[15 - k % 16];
      k++;
      cyc(2);
      if (rxc_q && !rx_word_clk_out) begin
        if (rj >= 0) chk("rx word", {8'h5A, 8'(rj)}, rx_word_out);
        rj++;
      end
      if (tx_word_clk_out && !txc_q) begin
        nfr++;
        if (skip > 0) skip--;
        else if (md == 1) chk("tx word", {8'hC3, lastw[7:0] + 8'h01}, txs);
        else if (md == 2) chk("idle pattern", IDLE_PATTERN, txs);
        lastw = txs;
      end
      txs = {txs[14:0], tx_serial_out};
      txc_q = tx_word_clk_out;
      rxc_q = rx_word_clk_out;
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    cyc(20);
    chk("driver in reset", 16'h0000, 16'(tx_serial_en_out));
    chk("fault in reset", 16'h0000, 16'(line_fault_n_out));
    @(posedge core_clk_in);
    resetn_in <= 1'b1;
    cyc(2);
    done("reset");
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk_in);
      signal_detect_in <= i[1];
      rx_vco_in_range_in <= i[0];
      cyc(2);
      chk("line fault", 16'(i == 3), 16'(line_fault_n_out));
    end
    done("line fault");
    md = 1;
    skip = 7;
    tick(160);
    done("stream");
    err_max = 0;
    md = 0;
    @(posedge core_clk_in);
    up_en <= 1'b0;
    tick(128);
    chk("underflow span", 16'h0001, 16'(err_max >= 1 && err_max <= CLR_LIMIT_CYC));
    done("underflow");
    err_max = 0;
    up_burst <= 1'b1;
    cyc(40);
    up_burst <= 1'b0;
    chk("overflow span", 16'h0001, 16'(err_max >= 1 && err_max <= CLR_LIMIT_CYC));
    done("overflow");
    tx_buffer_reset_n_in <= 1'b0;
    up_en <= 1'b1;
    md = 2;
    skip = 1;
    tick(48);
    @(posedge core_clk_in);
    tx_buffer_reset_n_in <= 1'b1;
    md = 1;
    skip = 7;
    nfr = 0;
    tick(160);
    chk("word clock count", 16'h000A, 16'(nfr));
    done("fifo reset");
    chk("rx overrun", 16'h0000, 16'(rx_overrun_out));
    @(posedge core_clk_in);
    standby_n_in <= 1'b0;
    cyc(3);
    chk("driver in standby", 16'h0000, 16'(tx_serial_en_out));
    chk("fault in standby", 16'h0000, 16'(line_fault_n_out));
    done("standby");
    finish_test();
  end
endmodule // sps_ctrl_test
`default_nettype wire

// ===== verif/sps_framer_model.sv
`timescale 1ns/1ns
`default_nettype none
module sps_framer_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Bench controls
  input wire logic enable_in,
  input wire logic burst_in,
  // Device side
  input wire logic word_clk_in,
  output logic word_clk_out,
  output logic [sps_pkg::WORD_W-1:0] word_out
);
  logic clk_q;
  logic [1:0] ph;
  logic [7:0] n;
  // Data inverted between strobes so a late sample is caught
  always @(posedge clk_in) begin
    clk_q <= word_clk_in;
    ph <= ph + 2'h1;
    if (!resetn_in) begin
      n <= 8'h00;
      ph <= 2'h0;
      word_clk_out <= 1'b0;
      word_out <= 16'h0000;
    end else if (!word_clk_out && ((enable_in && word_clk_in && !clk_q) || (burst_in && ph == 2'h0))) begin
      word_clk_out <= 1'b1;
      word_out <= {8'hC3, n};
      n <= n + 8'h01;
    end else begin
      word_clk_out <= 1'b0;
      word_out <= ~word_out;
    end
  end
endmodule // sps_framer_model
`default_nettype wire
